// ===== hw/burst_sram_pkg.sv
// shared constants and carrier types for the pipelined burst sram port
package burst_sram_pkg;
    localparam int ADDR_W = 17;                 // word address width
    localparam int LANES = 4;                   // write lanes per word
    localparam int LANE_W = 9;                  // bits per lane
    localparam int DATA_W = LANES * LANE_W;     // full word width
    localparam int PIPE_DEPTH = 2;              // load to data cycles
    localparam logic [1:0] BURST_START = 2'h0;  // burst step after load
    localparam logic [1:0] BURST_LAST = 2'h3;   // final step of a burst

    // control sampled at one edge
    typedef struct packed {
        logic advance_or_load;
        logic read_not_write;
        logic chip_select_a_n;
        logic chip_select_b;
        logic chip_select_c_n;
        logic [LANES-1:0] lane_write_enable_n;
        logic [ADDR_W-1:0] addr;
    } ctrl_t;

    // one pipeline slot: access waiting for its data cycle
    typedef struct packed {
        logic valid;
        logic is_write;
        logic [LANES-1:0] lane_write_enable_n;
        logic [ADDR_W-1:0] addr;
    } slot_t;
endpackage : burst_sram_pkg

// ===== hw/sram_array.sv
// lane-masked storage array with combinational read port
`timescale 1ns/1ps
module sram_array #(
    parameter int ADDR_W = 17,
    parameter int LANES = 4,
    parameter int LANE_W = 9
) (
    input wire logic clk_in,
    input wire logic clk_en_in,
    input wire logic wr_in,
    input wire logic [LANES-1:0] lane_wr_n_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [LANES*LANE_W-1:0] wdata_in,
    output logic [LANES*LANE_W-1:0] rdata_out
);
    // storage has no reset; contents survive sleep
    logic [LANES*LANE_W-1:0] mem [0:(1<<ADDR_W)-1];

    // per-lane write, gated by active-low lane enables
    always_ff @(posedge clk_in) begin
        if (clk_en_in && wr_in) begin
            for (int i = 0; i < LANES; i++) begin
                if (!lane_wr_n_in[i]) begin
                    mem[addr_in][i*LANE_W +: LANE_W] <= wdata_in[i*LANE_W +: LANE_W];
                end
            end
        end
    end

    // read is combinational from the array, registered by the caller
    assign rdata_out = mem[addr_in];
endmodule : sram_array

// ===== hw/burst_sram_port.sv
// control pipeline of a pipelined burst sram with no turnaround
// Function
// - address captured only on selected load
// - selected load starts fresh access
// - deselected load ends running burst
// - advance steps burst counter
// - address ignored while advancing
// - read/write level chosen at load
// - data transfer two cycles after load
// - clock enable high freezes burst state, pipe, array and read data
// - four 9-bit lanes, own enables
// - lane enables ignored on reads
// - lanes committed two cycles after sampling
// - deselect on load with false select
// - bus released two cycles after deselect
// - burst order select, static input
// - output enable asynchronously floats bus
// - sleep gates clock, keeps contents
// - active-high select mirrors active-low ones
`timescale 1ns/1ps
module burst_sram_port #(
    parameter int ADDR_W = burst_sram_pkg::ADDR_W,
    parameter int LANES = burst_sram_pkg::LANES,
    parameter int LANE_W = burst_sram_pkg::LANE_W
) (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic CLOCK_ENABLE_N_IN,
    input wire logic ADVANCE_OR_LOAD_IN,
    input wire logic READ_NOT_WRITE_IN,
    input wire logic CHIP_SELECT_A_N_IN,
    input wire logic CHIP_SELECT_B_IN,
    input wire logic CHIP_SELECT_C_N_IN,
    input wire logic [LANES-1:0] LANE_WRITE_ENABLE_N_IN,
    input wire logic [ADDR_W-1:0] ADDR_IN,
    input wire logic BURST_ORDER_SELECT_IN,
    input wire logic OUTPUT_ENABLE_N_IN,
    input wire logic SLEEP_REQUEST_IN,
    input wire logic [LANES*LANE_W-1:0] DATA_LANES_IN,
    output logic [LANES*LANE_W-1:0] DATA_LANES_OUT,
    output logic DATA_LANES_OE_OUT
);
    // pins other than output enable come from another domain: two flops first
    burst_sram_pkg::ctrl_t ctrl_meta_reg, ctrl_sync_reg, ctrl_pin;
    logic [2:0] misc_meta_reg, misc_sync_reg; // clock enable, sleep, order
    logic [LANES*LANE_W-1:0] din_meta_reg, din_sync_reg;
    // output enable stays off the sync path: it must float the bus at once

    assign ctrl_pin = '{advance_or_load: ADVANCE_OR_LOAD_IN, read_not_write: READ_NOT_WRITE_IN,
                        chip_select_a_n: CHIP_SELECT_A_N_IN, chip_select_b: CHIP_SELECT_B_IN,
                        chip_select_c_n: CHIP_SELECT_C_N_IN,
                        lane_write_enable_n: LANE_WRITE_ENABLE_N_IN, addr: ADDR_IN};

    // synchroniser stages, reset to idle pin levels
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ctrl_meta_reg <= '{advance_or_load: 1'b1, read_not_write: 1'b1,
                               chip_select_a_n: 1'b1, chip_select_b: 1'b0,
                               chip_select_c_n: 1'b1, lane_write_enable_n: '1, addr: '0};
            ctrl_sync_reg <= '{advance_or_load: 1'b1, read_not_write: 1'b1,
                               chip_select_a_n: 1'b1, chip_select_b: 1'b0,
                               chip_select_c_n: 1'b1, lane_write_enable_n: '1, addr: '0};
            misc_meta_reg <= 3'h1; // clock enable inactive
            misc_sync_reg <= 3'h1;
            din_meta_reg <= '0;
            din_sync_reg <= '0;
            // no output enable stage here; the pin acts without a clock
            // reset still floats the bus through drive_reg
        end else begin
            ctrl_meta_reg <= ctrl_pin;
            ctrl_sync_reg <= ctrl_meta_reg;
            misc_meta_reg <= {BURST_ORDER_SELECT_IN, SLEEP_REQUEST_IN, CLOCK_ENABLE_N_IN};
            misc_sync_reg <= misc_meta_reg;
            din_meta_reg <= DATA_LANES_IN;
            din_sync_reg <= din_meta_reg;
            // output enable handled combinationally at the pins
            // a sync stage would leave the bus driven for two cycles
        end
    end

    // decoded, already-synchronised controls
    logic interleave;
    logic adv;
    logic selected;
    logic step_en;
    assign interleave = misc_sync_reg[2];
    // internal clock gate: clock enable high or sleep high freezes the edge
    assign step_en = !misc_sync_reg[0] && !misc_sync_reg[1];
    assign adv = ctrl_sync_reg.advance_or_load;
    // active-high select folded in with its own sense, not inverted
    assign selected = !ctrl_sync_reg.chip_select_a_n && ctrl_sync_reg.chip_select_b
                      && !ctrl_sync_reg.chip_select_c_n;

    // burst address for a given step, linear or interleaved
    function automatic logic [1:0] burst_low(input logic [1:0] base, input logic [1:0] step,
                                             input logic ilv);
        burst_low = ilv ? (base ^ step) : 2'(base + step);
    endfunction : burst_low

    // burst state: base address, step count, direction
    logic [ADDR_W-1:0] base_reg;
    logic [1:0] step_reg;
    logic active_reg;
    logic write_burst_reg;

    // load, advance and terminate handling
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            base_reg <= '0;
            step_reg <= burst_sram_pkg::BURST_START;
            active_reg <= 1'b0;
            write_burst_reg <= 1'b0;
        end else if (step_en) begin
            if (!adv && selected) begin
                // fresh address and direction captured
                base_reg <= ctrl_sync_reg.addr;
                write_burst_reg <= !ctrl_sync_reg.read_not_write;
                step_reg <= burst_sram_pkg::BURST_START;
                active_reg <= 1'b1;
            end else if (!adv) begin
                active_reg <= 1'b0;
            end else if (active_reg) begin
                // address pins not looked at here
                step_reg <= 2'(step_reg + 2'h1);
            end
        end
    end

    // access issued this cycle
    burst_sram_pkg::slot_t issue;
    always_comb begin
        issue = '0;
        if (!adv && selected) begin
            issue.valid = 1'b1;
            issue.is_write = !ctrl_sync_reg.read_not_write;
            issue.addr = ctrl_sync_reg.addr;
        end else if (adv && active_reg) begin
            // burst beyond the last step wraps within the group
            issue.valid = 1'b1;
            issue.is_write = write_burst_reg;
            issue.addr = {base_reg[ADDR_W-1:2],
                          burst_low(base_reg[1:0], 2'(step_reg + 2'h1), interleave)};
        end
        // lanes only matter for writes
        issue.lane_write_enable_n = issue.is_write ? ctrl_sync_reg.lane_write_enable_n : '1;
    end

    // two-stage pipe from control edge to data edge
    burst_sram_pkg::slot_t pipe_reg [burst_sram_pkg::PIPE_DEPTH];
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pipe_reg[0] <= '0;
            pipe_reg[1] <= '0;
        end else if (step_en) begin
            // deselect enters an empty slot, releasing the bus two cycles on
            pipe_reg[0] <= issue;
            pipe_reg[1] <= pipe_reg[0];
        end
    end

    // array: write at the data edge, lanes as sampled two edges ago
    logic [LANES*LANE_W-1:0] rdata;
    sram_array #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LANE_W)) u_array (
        .clk_in(CLK_IN),
        .clk_en_in(step_en),
        .wr_in(pipe_reg[1].valid && pipe_reg[1].is_write),
        .lane_wr_n_in(pipe_reg[1].lane_write_enable_n),
        .addr_in(pipe_reg[1].addr),
        .wdata_in(din_sync_reg),
        .rdata_out(rdata)
    );

    // read data registered at the data edge; held when frozen
    logic [LANES*LANE_W-1:0] dout_reg;
    logic drive_reg;
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            dout_reg <= '0;
            drive_reg <= 1'b0;
        end else if (step_en) begin
            drive_reg <= pipe_reg[1].valid && !pipe_reg[1].is_write;
            if (pipe_reg[1].valid && !pipe_reg[1].is_write) begin
                dout_reg <= rdata;
            end
        end
    end

    // output enable overrides drive without waiting for an enabled edge
    assign DATA_LANES_OUT = dout_reg;
    assign DATA_LANES_OE_OUT = drive_reg && !OUTPUT_ENABLE_N_IN;
endmodule : burst_sram_port

// ===== test/sram_port_assertions.sv
// pin-level assertions for the burst sram port
`timescale 1ns/1ps
module sram_port_checker #(
    parameter int LANES = 4,
    parameter int LANE_W = 9
) (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic CLOCK_ENABLE_N_IN,
    input wire logic ADVANCE_OR_LOAD_IN,
    input wire logic READ_NOT_WRITE_IN,
    input wire logic CHIP_SELECT_A_N_IN,
    input wire logic CHIP_SELECT_B_IN,
    input wire logic CHIP_SELECT_C_N_IN,
    input wire logic OUTPUT_ENABLE_N_IN,
    input wire logic SLEEP_REQUEST_IN,
    input wire logic [LANES*LANE_W-1:0] DATA_LANES_OUT,
    input wire logic DATA_LANES_OE_OUT
);
    logic run; // edge not frozen
    logic sel; // all three selects true
    assign run = !CLOCK_ENABLE_N_IN && !SLEEP_REQUEST_IN;
    assign sel = !CHIP_SELECT_A_N_IN && CHIP_SELECT_B_IN && !CHIP_SELECT_C_N_IN;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    // pins pass a two-flop sync, so a load shows on the bus five samples on
    sequence s_load(bit rd);
        run && sel && !ADVANCE_OR_LOAD_IN && READ_NOT_WRITE_IN == rd;
    endsequence
    sequence s_drop;
        run && !ADVANCE_OR_LOAD_IN && !sel;
    endsequence
    sequence s_step;
        run && ADVANCE_OR_LOAD_IN;
    endsequence
    sequence s_carry;
        run [*2];
    endsequence
    a_read_drives:
        assert property (s_load(1) ##1 s_carry |-> ##3 (DATA_LANES_OE_OUT || OUTPUT_ENABLE_N_IN))
        else $error("read load did not drive the bus");
    a_write_floats:
        assert property (s_load(0) ##1 s_carry |-> ##3 !DATA_LANES_OE_OUT) else $error("write load drove the bus");
    a_deselect_floats:
        assert property (s_drop ##1 s_carry |-> ##3 !DATA_LANES_OE_OUT) else $error("bus driven after deselect");
    a_high_select_low:
        assert property ((run && !ADVANCE_OR_LOAD_IN && !CHIP_SELECT_B_IN) ##1 s_carry |-> ##3 !DATA_LANES_OE_OUT)
        else $error("low active-high select still read");
    a_advance_reads:
        assert property (s_load(1) ##1 s_step ##1 s_carry |-> ##3 (DATA_LANES_OE_OUT || OUTPUT_ENABLE_N_IN))
        else $error("advance did not continue read burst");
    a_burst_ends:
        assert property (s_drop ##1 s_step ##1 s_carry |-> ##3 !DATA_LANES_OE_OUT) else $error("burst ran on");
    a_freeze_holds:
        assert property (!run |-> ##3 $stable(DATA_LANES_OUT)) else $error("read data moved on frozen edge");
    a_oe_floats:
        assert property (OUTPUT_ENABLE_N_IN |-> !DATA_LANES_OE_OUT) else $error("bus driven with output off");
endmodule : sram_port_checker

bind burst_sram_port sram_port_checker #(.LANES(LANES), .LANE_W(LANE_W)) u_chk (.CLK_IN, .RST_IN,
    .CLOCK_ENABLE_N_IN, .ADVANCE_OR_LOAD_IN, .READ_NOT_WRITE_IN, .CHIP_SELECT_A_N_IN, .CHIP_SELECT_B_IN,
    .CHIP_SELECT_C_N_IN, .OUTPUT_ENABLE_N_IN, .SLEEP_REQUEST_IN, .DATA_LANES_OUT, .DATA_LANES_OE_OUT);

// ===== test/ctrl_model.sv
// memory controller model driving control, address and write data
`timescale 1ns/1ps
module ctrl_model (
    output burst_sram_pkg::ctrl_t ctrl_out,
    output logic clock_enable_n_out,
    output logic sleep_request_out,
    output logic [35:0] wdata_out
);
    logic [36:0] wq [2]; // write data waiting two ticks, top bit marks it real
    logic wr_burst; // advances keep writing
    // one tick: kind 0 read, 1 write, 2 advance, 3 deselect, 4 clock off, 5 sleep
    task automatic drive(input int kind, input logic [16:0] a, input logic [3:0] ln, input logic [35:0] d);
        logic wr;
        wr = kind == 1 || (kind == 2 && wr_burst);
        clock_enable_n_out = kind == 4;
        sleep_request_out = kind == 5;
        ctrl_out = {kind == 2, kind != 1, kind == 3 && a[0], !(kind == 3 && a[1]), kind == 3 && a[2], ln, a};
        if (kind < 4) begin
            // idle data bus shows the inverse of its last value, so a stale word returns every second idle tick
            wdata_out = wq[1][36] ? wq[1][35:0] : ~wdata_out;
            wq[1] = wq[0];
            wq[0] = {wr, d};
            if (kind != 2) wr_burst = kind == 1;
        end
    endtask : drive
    initial begin
        wq[0] = '0;
        wq[1] = '0;
        wdata_out = '0;
        wr_burst = 1'b0;
        drive(3, 17'h00001, 4'hF, 36'h0);
    end
endmodule : ctrl_model

// ===== test/tb_top.sv
// self-checking bench for the burst sram port
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [2:0] kind;
        logic [16:0] a;
        logic [3:0] ln;
        logic [35:0] d;
    } row_t;
    localparam int N = 20;
    // freezes sit where the pipe holds no read, so one fixed latency fits every row
    row_t rows [N] = '{'{3'h1, 17'h00100, 4'h0, 36'h111111111}, '{3'h2, 17'h1FFFF, 4'h0, 36'h222222222},
        '{3'h1, 17'h00102, 4'h0, 36'h333333333}, '{3'h1, 17'h00103, 4'h0, 36'h444444444},
        '{3'h1, 17'h00102, 4'hA, 36'hABCDEF012}, '{3'h3, 17'h00002, 4'hF, 36'h0}, '{3'h2, 17'h1FFFF, 4'h0, 36'h0},
        '{3'h4, 17'h00100, 4'h0, 36'h0}, '{3'h0, 17'h00101, 4'h0, 36'h0}, '{3'h2, 17'h1FFFF, 4'h0, 36'h0},
        '{3'h2, 17'h00000, 4'h0, 36'h0}, '{3'h2, 17'h1FFFF, 4'h0, 36'h0}, '{3'h2, 17'h1FFFF, 4'h0, 36'h0},
        '{3'h3, 17'h00001, 4'hF, 36'h0}, '{3'h3, 17'h00004, 4'hF, 36'h0}, '{3'h2, 17'h1FFFF, 4'h0, 36'h0},
        '{3'h5, 17'h00100, 4'h0, 36'h0}, '{3'h0, 17'h00103, 4'h0, 36'h0}, '{3'h0, 17'h00102, 4'h0, 36'h0},
        '{3'h3, 17'h00001, 4'hF, 36'h0}};
    logic clk, rst, oe_n, order, cen_n, sleep, oe;
    logic [35:0] wdata, rdata;
    burst_sram_pkg::ctrl_t ctrl;
    logic [35:0] mem [logic [16:0]]; // expected array contents
    int err_count = 0;
    int comparisons = 0;
    ctrl_model u_ctrl (.ctrl_out(ctrl), .clock_enable_n_out(cen_n), .sleep_request_out(sleep), .wdata_out(wdata));
    burst_sram_port u_dut (.CLK_IN(clk), .RST_IN(rst), .CLOCK_ENABLE_N_IN(cen_n),
        .ADVANCE_OR_LOAD_IN(ctrl.advance_or_load), .READ_NOT_WRITE_IN(ctrl.read_not_write),
        .CHIP_SELECT_A_N_IN(ctrl.chip_select_a_n), .CHIP_SELECT_B_IN(ctrl.chip_select_b),
        .CHIP_SELECT_C_N_IN(ctrl.chip_select_c_n), .LANE_WRITE_ENABLE_N_IN(ctrl.lane_write_enable_n),
        .ADDR_IN(ctrl.addr), .BURST_ORDER_SELECT_IN(order), .OUTPUT_ENABLE_N_IN(oe_n), .SLEEP_REQUEST_IN(sleep),
        .DATA_LANES_IN(wdata), .DATA_LANES_OUT(rdata), .DATA_LANES_OE_OUT(oe));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input logic [35:0] seen, input logic [35:0] want);
        comparisons++;
        if (seen !== want) begin
            err_count++;
            $display("mismatch at %0t: seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up
    // table rows go out one per tick; each row's bus result is checked five ticks later
    task automatic run_table(input logic ilv);
        logic [16:0] base, ea;
        logic [1:0] step;
        logic act, rd;
        logic [36:0] want [N];
        act = 1'b0;
        rd = 1'b0;
        for (int i = 0; i < N + 5; i++) begin
            @(negedge clk);
            if (i >= 5) check(36'(oe), 36'(want[i-5][36]));
            if (i >= 5 && want[i-5][36]) check(rdata, want[i-5][35:0]);
            if (i < N) begin
                want[i] = '0;
                if (rows[i].kind < 3'h2) begin
                    base = rows[i].a;
                    step = 2'h0;
                    act = 1'b1;
                    rd = rows[i].kind == 3'h0;
                end else if (rows[i].kind == 3'h2 && act) step = step + 2'h1;
                else if (rows[i].kind == 3'h3) act = 1'b0;
                ea = {base[16:2], ilv ? base[1:0] ^ step : base[1:0] + step};
                if (act && rows[i].kind < 3'h3 && rd) want[i] = {1'b1, mem[ea]};
                else if (act && rows[i].kind < 3'h3) for (int j = 0; j < 4; j++)
                    if (!rows[i].ln[j]) mem[ea][j*9+:9] = rows[i].d[j*9+:9];
                u_ctrl.drive(rows[i].kind, rows[i].a, rows[i].ln, rows[i].d);
            end
        end
    endtask : run_table
    initial begin
        rst = 1'b1;
        oe_n = 1'b0;
        order = 1'b0;
        repeat (20) @(negedge clk);
        check(rdata, 36'h0);
        check(36'(oe), 36'h0);
        $display("test reset done");
        rst = 1'b0;
        run_table(1'b0);
        $display("test linear table done");
        rst = 1'b1;
        order = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        run_table(1'b1);
        $display("test interleaved table done");
        for (int k = 0; k < 2; k++) begin
            oe_n = !k[0];
            @(negedge clk);
            u_ctrl.drive(0, 17'h00100, 4'h0, 36'h0);
            repeat (5) begin
                @(negedge clk);
                u_ctrl.drive(3, 17'h00001, 4'hF, 36'h0);
            end
            check(36'(oe), 36'(k));
        end
        check(rdata, 36'h111111111);
        $display("test output enable done");
        wrap_up();
    end
    initial begin
        #20000;
        err_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule : tb_top
